/* File: ubt_pkg.sv */
// Purpose: shared constants and types for the serial bit-timing and receive sampler
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: offsets are byte addresses

package ubt_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DIV_OFFSET = 8'h04;
    localparam logic [7:0] STAT_OFFSET = 8'h08;
    localparam logic [7:0] DATA_OFFSET = 8'h0C;
    // control field positions
    localparam int CTRL_RX_EN_BIT = 0;
    localparam int CTRL_PAR_EN_BIT = 1;
    localparam int CTRL_STOP2_BIT = 2;
    localparam int CTRL_SRC_BIT = 3;
    localparam int CTRL_BTS_LSB = 4;
    // reset values
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [2:0] BTS_RESET = 3'h0;
    // bit time select codes
    localparam logic [2:0] BTS_16 = 3'h0;
    localparam logic [2:0] BTS_16_17 = 3'h1;
    localparam logic [2:0] BTS_15 = 3'h2;
    localparam logic [2:0] BTS_15_16 = 3'h3;
    localparam logic [2:0] BTS_17 = 3'h4;
    // tick index values
    localparam logic [4:0] TICK_START_17 = 5'h10;
    localparam logic [4:0] TICK_START_16 = 5'h0F;
    localparam logic [4:0] TICK_START_15 = 5'h0E;
    localparam logic [4:0] TICK_SAMPLE_A = 5'h08;
    localparam logic [4:0] TICK_SAMPLE_B = 5'h07;
    localparam logic [4:0] TICK_SAMPLE_C = 5'h06;
    localparam int DATA_BITS = 8;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // received word with its error flags
    typedef struct packed {
        logic framing_err;
        logic parity_err;
        logic [7:0] data;
    } ubt_word_t;

    // receiver phases
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ubt_rx_state_t;
endpackage

/* File: ubt_buffer.sv */
// Purpose: two-entry valid/ready buffer for received words
// Assumes: single clock, synchronous active-high reset
// Notes: full when two words held; in_ready deasserts then

`timescale 1ns/1ns

module ubt_buffer import ubt_pkg::*; #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous reset
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word in
    output logic out_valid, // word available
    input wire logic out_ready, // consumer takes word
    output logic [WIDTH-1:0] out_data // oldest word
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] wr_ptr;
    logic [$clog2(DEPTH)-1:0] rd_ptr;
    logic [$clog2(DEPTH):0] count;
    logic push;
    logic pop;

    // handshake terms
    assign in_ready = (count != DEPTH[$clog2(DEPTH):0]);
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
        end
    end
endmodule // ubt_buffer

/* File: ubt_rx_sampler.sv */
// Purpose: oversampling tick generator and receive sampler with AXI4-Lite registers
// Assumes: receive line synchronous to clk; low-speed clock enable is synchronous
// Notes: received words pass a two-entry buffer read through the data register
//
// Overview of operation
// R1: tick every divisor plus one source counts
// R2: bit time is 15 to 17 ticks
// R3: codes 000/010/100 give 16/15/17 ticks
// R4: codes 001/011 alternate, start bit shorter
// R5: falling edge while idle starts tick counting
// R6: tick index counts down to zero per bit
// R7: sample at 8,7,6; majority of three
// R8: sample points fixed for every select code
// R9: high start bit abandons frame, await edge
// R10: software keeps rate error within three percent
// R11: start, eight data lsb first, parity, stops
// R12: divisor and tick counter reload at frame start
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.

`timescale 1ns/1ns

module ubt_rx_sampler import ubt_pkg::*; #(
    parameter int DIV_WIDTH = 8
) (
    input wire logic clk, // system clock, 50 MHz
    input wire logic reset, // synchronous reset
    input wire logic low_speed_clock, // low-speed source clock enable pulse
    input wire logic receive_line, // serial input
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read response valid
    input wire logic s_axi_rready, // read response ready
    output logic oversample_tick, // one-cycle tick pulse
    output logic rx_busy // frame in progress
);
    // control fields
    logic rx_enable;
    logic parity_enable;
    logic stop_bit_count;
    logic source_clock_select;
    logic [2:0] bit_time_select;
    logic [DIV_WIDTH-1:0] baud_divisor;
    logic [7:0] false_starts;
    // timing
    logic [DIV_WIDTH-1:0] div_count;
    logic tick;
    logic src_pulse;
    logic [4:0] tick_index;
    logic long_bit;
    logic line_prev;
    // receiver
    ubt_rx_state_t state;
    logic [2:0] votes;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic parity_acc;
    logic parity_err;
    logic stop_second;
    logic voted;
    logic frame_start;
    logic bit_end;
    logic push_valid;
    ubt_word_t push_word;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_pop;
    ubt_word_t buf_word;
    // bus
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // start count of the tick index for one bit
    function automatic logic [4:0] bit_start(input logic [2:0] sel, input logic alt_long);
        unique case (sel)
            BTS_16: bit_start = TICK_START_16; // [R3]
            BTS_15: bit_start = TICK_START_15; // [R3]
            BTS_17: bit_start = TICK_START_17; // [R3]
            BTS_16_17: bit_start = alt_long ? TICK_START_17 : TICK_START_16; // [R4]
            BTS_15_16: bit_start = alt_long ? TICK_START_16 : TICK_START_15; // [R4]
            default: bit_start = TICK_START_16;
        endcase
    endfunction

    // 2-of-3 vote
    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction

    assign src_pulse = source_clock_select ? low_speed_clock : 1'b1;
    assign frame_start = (state == RX_IDLE) && rx_enable && line_prev && !receive_line; // [R5]
    assign tick = src_pulse && (div_count == baud_divisor) && (state != RX_IDLE);
    assign bit_end = tick && (tick_index == 5'h00); // [R6]
    assign voted = majority(votes); // [R7]

    // divisor counter, tick after divisor plus one source counts
    always_ff @(posedge clk) begin
        if (reset || frame_start || state == RX_IDLE) begin
            div_count <= '0; // [R12]
        end else if (src_pulse) begin
            div_count <= (div_count == baud_divisor) ? '0 : div_count + 1'b1; // [R1]
        end
    end

    // tick output register
    always_ff @(posedge clk) begin
        if (reset) begin
            oversample_tick <= 1'b0;
        end else begin
            oversample_tick <= tick; // [R1]
        end
    end

    // per-bit tick index, counting down
    always_ff @(posedge clk) begin
        if (reset) begin
            tick_index <= TICK_START_16;
            long_bit <= 1'b0;
        end else if (frame_start) begin
            tick_index <= bit_start(bit_time_select, 1'b0); // [R12] [R4]
            long_bit <= 1'b1;
        end else if (bit_end) begin
            tick_index <= bit_start(bit_time_select, long_bit); // [R2]
            long_bit <= !long_bit;
        end else if (tick) begin
            tick_index <= tick_index - 5'h01; // [R6]
        end
    end

    // line history for edge detection
    always_ff @(posedge clk) begin
        if (reset) begin
            line_prev <= 1'b1;
        end else begin
            line_prev <= receive_line;
        end
    end

    // samples taken at fixed indices regardless of select code
    always_ff @(posedge clk) begin
        if (reset || frame_start) begin
            votes <= 3'h0;
        end else if (tick) begin
            if (tick_index == TICK_SAMPLE_A) begin
                votes[2] <= receive_line; // [R7] [R8]
            end
            if (tick_index == TICK_SAMPLE_B) begin
                votes[1] <= receive_line; // [R7] [R8]
            end
            if (tick_index == TICK_SAMPLE_C) begin
                votes[0] <= receive_line; // [R7] [R8]
            end
        end
    end

    // frame sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= RX_IDLE;
            bit_count <= 4'h0;
            shift <= 8'h00;
            parity_acc <= 1'b0;
            parity_err <= 1'b0;
            stop_second <= 1'b0;
            false_starts <= 8'h00;
            push_valid <= 1'b0;
            push_word <= '0;
        end else begin
            if (push_valid && buf_in_ready) begin
                push_valid <= 1'b0;
            end
            unique case (state)
                RX_IDLE: begin
                    if (frame_start) begin
                        state <= RX_START;
                    end
                end
                RX_START: begin
                    if (!rx_enable) begin
                        state <= RX_IDLE;
                    end else if (tick && tick_index == TICK_SAMPLE_C - 5'h01) begin
                        if (voted) begin // [R7]
                            state <= RX_IDLE; // [R9]
                            false_starts <= false_starts + 8'h01;
                        end
                    end else if (bit_end) begin
                        state <= RX_DATA; // [R11]
                        bit_count <= 4'h0;
                        parity_acc <= 1'b0;
                    end
                end
                RX_DATA: begin
                    if (bit_end) begin
                        shift <= {voted, shift[7:1]}; // [R11]
                        parity_acc <= parity_acc ^ voted;
                        bit_count <= bit_count + 4'h1;
                        if (bit_count == 4'(DATA_BITS - 1)) begin
                            state <= parity_enable ? RX_PARITY : RX_STOP; // [R11]
                            stop_second <= 1'b0;
                        end
                    end
                end
                RX_PARITY: begin
                    if (bit_end) begin
                        parity_err <= parity_acc ^ voted; // even parity
                        state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (bit_end) begin
                        if (stop_bit_count && !stop_second && voted) begin
                            stop_second <= 1'b1; // [R11]
                        end else begin
                            state <= RX_IDLE;
                            push_valid <= 1'b1; // word held until the buffer has room
                            push_word <= '{framing_err: !voted,
                                           parity_err: parity_enable && parity_err,
                                           data: shift};
                            parity_err <= 1'b0;
                        end
                    end
                end
                default: state <= RX_IDLE;
            endcase
        end
    end

    ubt_buffer #(
        .WIDTH($bits(ubt_word_t)),
        .DEPTH(2)
    ) u_buffer (
        .clk(clk),
        .reset(reset),
        .in_valid(push_valid),
        .in_ready(buf_in_ready),
        .in_data(push_word),
        .out_valid(buf_out_valid),
        .out_ready(buf_pop),
        .out_data(buf_word)
    );

    // busy flag register
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_busy <= 1'b0;
        end else begin
            rx_busy <= (state != RX_IDLE);
        end
    end

    // write channel capture and response
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == CTRL_OFFSET || aw_addr == DIV_OFFSET)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    // control registers, written in byte lane 0
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_enable <= 1'b0;
            parity_enable <= 1'b0;
            stop_bit_count <= 1'b0;
            source_clock_select <= 1'b0;
            bit_time_select <= BTS_RESET;
            baud_divisor <= DIV_WIDTH'(DIV_RESET);
        end else if (aw_held && w_held && !s_axi_bvalid && w_strb[0]) begin
            if (aw_addr == CTRL_OFFSET) begin
                rx_enable <= w_data[CTRL_RX_EN_BIT];
                parity_enable <= w_data[CTRL_PAR_EN_BIT];
                stop_bit_count <= w_data[CTRL_STOP2_BIT];
                source_clock_select <= w_data[CTRL_SRC_BIT];
                bit_time_select <= w_data[CTRL_BTS_LSB +: 3];
            end else if (aw_addr == DIV_OFFSET) begin
                baud_divisor <= w_data[DIV_WIDTH-1:0];
            end
        end
    end

    // read channel; data register read pops the buffer
    assign buf_pop = s_axi_arvalid && s_axi_arready && (s_axi_araddr == DATA_OFFSET);
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                CTRL_OFFSET: s_axi_rdata <= {25'h0, bit_time_select, source_clock_select,
                                             stop_bit_count, parity_enable, rx_enable};
                DIV_OFFSET: s_axi_rdata <= 32'(baud_divisor);
                STAT_OFFSET: s_axi_rdata <= {16'h0, false_starts, 3'h0, state,
                                             buf_in_ready, buf_out_valid};
                DATA_OFFSET: s_axi_rdata <= {21'h0, buf_out_valid, 10'(buf_word)};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // ubt_rx_sampler

/* File: ubt_rx_sampler_sva.sv */
// Purpose: port checker for the receive sampler
// Assumes: one clock, synchronous reset
// Notes: bound by name after the module
`timescale 1ns/1ns
module ubt_rx_sampler_sva import ubt_pkg::*; (
    input wire logic clk, // clock
    input wire logic reset, // reset
    input wire logic receive_line, // serial in
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r resp
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic oversample_tick, // tick
    input wire logic rx_busy // busy
);
    // every check on clk, quiet in reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved");
    b_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late or early");
    r_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("refused read carries data");
    busy_start_a: assert property ($rose(rx_busy) |-> !$past(receive_line))
        else $error("frame began without low line");
    tick_idle_a: assert property (!rx_busy [*3] |-> !oversample_tick)
        else $error("tick outside a frame");
endmodule // ubt_rx_sampler_sva
bind ubt_rx_sampler ubt_rx_sampler_sva sva_u (.clk(clk), .reset(reset),
    .receive_line(receive_line), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .oversample_tick(oversample_tick), .rx_busy(rx_busy));

/* File: ubt_remote_peer.sv */
// Purpose: remote serial sender facing the receive line
// Assumes: cpt is clk cycles per oversampling tick
// Notes: sends at the exact rate, so no rate error
`timescale 1ns/1ns
module ubt_remote_peer import ubt_pkg::*; (
    input wire logic clk, // system clock
    output logic line // serial out, idle high
);
    initial line = 1'h1;
    // one frame, optionally with a bad parity or stop bit
    task automatic send(input logic [7:0] d, input logic [2:0] bts, input int cpt,
        input logic par, input logic two, input logic [1:0] bad);
        logic [11:0] fr;
        int n;
        int len;
        fr = {3'h7, d, 1'h0};
        if (par) fr[9] = ^d ^ bad[0];
        fr[9 + par] = !bad[1];
        n = 10 + par + two;
        for (int i = 0; i < n; i++) begin
            len = (bts == BTS_15 || bts == BTS_15_16) ? 15 : (bts == BTS_17) ? 17 : 16;
            if ((bts == BTS_16_17 || bts == BTS_15_16) && i[0]) len++;
            line <= fr[i];
            repeat (len * cpt) @(posedge clk);
        end
        line <= 1'h1;
        repeat (16 * cpt) @(posedge clk);
    endtask
    // short low pulse that is not a start bit
    task automatic glitch(input int n);
        line <= 1'h0;
        repeat (n) @(posedge clk);
        line <= 1'h1;
        repeat (8 * n) @(posedge clk);
    endtask
endmodule // ubt_remote_peer

/* File: ubt_rx_sampler_test.sv */
// Purpose: self-checking bench for the receive sampler
// Assumes: 50 MHz clock, reset held six cycles
// Notes: a monitor scores answers against queued notes
`timescale 1ns/1ns
module ubt_rx_sampler_test import ubt_pkg::*;;
    logic clk = 1'h0, reset = 1'h1, low_speed_clock = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, tick, busy;
    logic [1:0] bresp, rresp;
    wire line;
    int errors = 0, total_checks = 0, cycles = 0, gap = -1, exp_gap = 3;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    always #10 clk = ~clk;
    ubt_rx_sampler dut_u (.clk(clk), .reset(reset), .low_speed_clock(low_speed_clock),
        .receive_line(line), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .oversample_tick(tick), .rx_busy(busy));
    ubt_remote_peer peer_u (.clk(clk), .line(line));
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, e, s);
        end
    endtask
    // cycle count, low-speed pulse every third cycle, hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        low_speed_clock <= (cycles % 3 == 2);
        if (cycles == 60000) begin
            errors = errors + 1;
            close_out();
        end
    end
    // monitor: answers against notes, tick spacing inside frames
    always @(posedge clk) begin
        if (rvalid === 1'h1 && rready === 1'h1) chk("read", rq.pop_front(), {rresp, rdata});
        if (bvalid === 1'h1 && bready === 1'h1) chk("bresp", wq.pop_front(), bresp);
        if (busy !== 1'h1) gap <= -1;
        else if (tick === 1'h1) begin
            if (gap > 0) chk("tick gap", exp_gap, gap);
            gap <= 1;
        end else if (gap >= 0) gap <= gap + 1;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        wq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        fork
            begin
                do @(negedge clk); while (awready !== 1'h1);
                @(posedge clk);
                awvalid <= 1'h0;
            end
            begin
                do @(negedge clk); while (wready !== 1'h1);
                @(posedge clk);
                wvalid <= 1'h0;
            end
        join
        repeat ($urandom_range(3)) @(posedge clk);
        bready <= 1'h1;
        do @(negedge clk); while (bvalid !== 1'h1);
        @(posedge clk);
        bready <= 1'h0;
    endtask
    // read with a random stall before taking the answer
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'h1;
        do @(negedge clk); while (arready !== 1'h1);
        @(posedge clk);
        arvalid <= 1'h0;
        repeat ($urandom_range(3)) @(posedge clk);
        rready <= 1'h1;
        do @(negedge clk); while (rvalid !== 1'h1);
        @(posedge clk);
        rready <= 1'h0;
    endtask
    // configure, receive one frame, read the word back
    task automatic rx(input logic [7:0] d, input logic [2:0] bts, input logic par,
        input logic two, input logic [1:0] bad, input logic src, input int cpt);
        wr(CTRL_OFFSET, {25'h0, bts, src, two, par, 1'h1}, RESP_OKAY);
        peer_u.send(d, bts, cpt, par, two, bad);
        rd(DATA_OFFSET, {RESP_OKAY, 21'h0, 1'h1, bad[1], bad[0] & par, d});
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h3240482E));
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        rd(CTRL_OFFSET, 34'h0);
        rd(DIV_OFFSET, {RESP_OKAY, 24'h0, DIV_RESET});
        rd(STAT_OFFSET, 34'h2);
        rd(8'h10, {RESP_SLVERR, 32'h0});
        wr(8'h20, 32'hFF, RESP_SLVERR);
        wr(STAT_OFFSET, 32'hFF, RESP_SLVERR);
        wr(DIV_OFFSET, 32'h2, RESP_OKAY);
        rd(DIV_OFFSET, 34'h2);
        // lane 0 off: write answered, divisor kept
        wstrb <= 4'hE;
        wr(DIV_OFFSET, 32'h7, RESP_OKAY);
        wstrb <= 4'hF;
        rd(DIV_OFFSET, 34'h2);
        // every select code, with and without parity and second stop
        for (int k = 0; k < 10; k++) begin
            rx(8'($urandom), 3'(k % 5), k >= 5, k[0], 2'h0, 1'h0, 3);
        end
        rx(8'($urandom), BTS_17, 1'h1, 1'h0, 2'h1, 1'h0, 3);
        rx(8'($urandom), BTS_16_17, 1'h0, 1'h0, 2'h2, 1'h0, 3);
        // false start, then a good frame right after
        peer_u.glitch(12);
        rd(STAT_OFFSET, {RESP_OKAY, 32'h102});
        rx(8'h5A, BTS_16, 1'h0, 1'h0, 2'h0, 1'h0, 3);
        // fill the buffer, then drain it
        peer_u.send(8'hA5, BTS_16, 3, 1'h0, 1'h0, 2'h0);
        peer_u.send(8'h3C, BTS_16, 3, 1'h0, 1'h0, 2'h0);
        rd(STAT_OFFSET, {RESP_OKAY, 32'h101});
        rd(DATA_OFFSET, 34'h4A5);
        rd(DATA_OFFSET, 34'h43C);
        rd(STAT_OFFSET, 34'h102);
        // low-speed source, divisor one
        wr(DIV_OFFSET, 32'h1, RESP_OKAY);
        exp_gap = 6;
        rx(8'($urandom), BTS_15_16, 1'h0, 1'h0, 2'h0, 1'h1, 6);
        close_out();
    end
endmodule // ubt_rx_sampler_test
